// File: logic/epoc_top.sv
// energy pulse output configuration registers with spi access and pulse generators
// Contract
// - second long bit: width from timer field
// - long bit clear: fixed 80 ms low
// - first long bit governs first output
// - 19-bit timer sets long pulse width
// - read-only temperature offset and gain trim
// - dip/swell irq repeated or entry/exit
// - burst reads enabled, crc dropped
// - accumulator clear bit pulses, self clears
// - zero crossing routed to second pin
// - sample ready routed to second pin
// - soft reset bit starts reset, clears
// - second disable holds pin high unless a route bit is set
// - disabled output sets no status flag
// - first disable likewise, holds pin high
// - second energy type select field
// - first energy type, same encoding
// - line frequency select 50/60 Hz
// - reactive accumulation mode field
// - active accumulation mode field
// - pulse counted at pin falling edge
`timescale 1ns/100ps
`include "epoc_map.svh"

module epoc_top #(
   parameter int FIXED_PULSE_CYC = `EPOC_FIXED_PULSE_MS * (`EPOC_CLK_HZ / 1000)
) (
   // clock, reset, enable
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   // spi pins
   input wire logic SCLK_IN,
   input wire logic CS_N_IN,
   input wire logic MOSI_IN,
   output logic MISO_OUT,
   output logic MISO_OE_OUT,
   // metrology events
   input wire logic FIRST_PULSE_EVT_IN,
   input wire logic SECOND_PULSE_EVT_IN,
   input wire logic ZERO_CROSS_IN,
   input wire logic SAMPLE_READY_IN,
   input wire logic DIP_SWELL_ACTIVE_IN,
   input wire logic DIP_SWELL_CYCLE_IN,
   // trim values
   input wire logic [15:0] TRIM_OFFSET_IN,
   input wire logic [15:0] TRIM_GAIN_IN,
   // pulse pins and status
   output logic FIRST_PULSE_PIN_OUT,
   output logic SECOND_PULSE_PIN_OUT,
   output logic FIRST_PULSE_STATUS_OUT,
   output logic SECOND_PULSE_STATUS_OUT,
   output logic DIP_SWELL_IRQ_OUT,
   // configuration to metrology
   output epoc_pkg::epoc_etype_t FIRST_ENERGY_TYPE_OUT,
   output epoc_pkg::epoc_etype_t SECOND_ENERGY_TYPE_OUT,
   output epoc_pkg::epoc_accum_t ACTIVE_ACCUM_MODE_OUT,
   output epoc_pkg::epoc_accum_t REACTIVE_ACCUM_MODE_OUT,
   output logic LINE_FREQ_60HZ_OUT,
   output logic EXTERNAL_REF_SEL_OUT,
   output logic [1:0] POWER_SETTLE_TIME_OUT,
   output logic ACCUM_CLEAR_OUT,
   output logic SOFT_RESET_OUT
);
   import epoc_pkg::*;

   localparam logic [19:0] FIXED_W = 20'(FIXED_PULSE_CYC);

   logic [2:0] sclk_s_r;
   logic [2:0] cs_s_r;
   logic [2:0] mosi_s_r;
   logic sclk_st_r;
   logic sclk_prev_r;
   logic cs_st_r;
   logic mosi_st_r;
   logic sclk_rise;
   logic sclk_fall;

   epoc_spi_e spi_state_r;
   logic [5:0] bit_cnt_r;
   epoc_addr_t addr_r;
   logic [15:0] cmd_sh_r;
   logic [31:0] rx_sh_r;
   logic [31:0] tx_sh_r;
   logic [15:0] crc_r;
   logic miso_r;
   logic miso_oe_r;
   logic wr_stb_r;
   epoc_addr_t wr_addr_r;
   logic [31:0] wr_data_r;

   logic [31:0] pwc_r;
   logic [15:0] cfg1_r;
   logic [15:0] mode_r;
   logic [15:0] acc_r;
   logic acc_clr_r;
   logic sw_rst_r;

   logic first_pin_r;
   logic second_pin_r;
   logic first_stat_r;
   logic second_stat_r;
   logic dip_irq_r;
   logic dip_prev_r;

   logic [1:0] pulse_evt;
   logic [1:0] pulse_dis;
   logic [1:0] pulse_long;
   logic [1:0] pulse_low;
   logic [1:0] pulse_start;

   // register width in bits for a given address
   function automatic logic [5:0] reg_width(input epoc_addr_t a);
      if (a == `EPOC_ADDR_PULSE_WIDTH || a == `EPOC_ADDR_TRIM)
         return 6'h20;
      return 6'h10;
   endfunction

   // read value, left aligned; self clearing bits and reserved bits read zero
   function automatic logic [31:0] read_word(input epoc_addr_t a);
      case (a)
         `EPOC_ADDR_PULSE_WIDTH: return pwc_r & `EPOC_PWC_WMASK;
         `EPOC_ADDR_TRIM: return {TRIM_OFFSET_IN, TRIM_GAIN_IN};
         `EPOC_ADDR_CONFIG_ONE: return {cfg1_r & `EPOC_CFG1_WMASK, 16'h0000};
         `EPOC_ADDR_PULSE_MODE: return {mode_r & `EPOC_MODE_WMASK, 16'h0000};
         `EPOC_ADDR_ACCUM_MODE: return {acc_r & `EPOC_ACC_WMASK, 16'h0000};
         default: return 32'h00000000;
      endcase
   endfunction

   // pin synchronisers, a level counts once stages two and three agree
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         sclk_s_r <= 3'h7;
         cs_s_r <= 3'h7;
         mosi_s_r <= 3'h0;
         sclk_st_r <= 1'b1;
         sclk_prev_r <= 1'b1;
         cs_st_r <= 1'b1;
         mosi_st_r <= 1'b0;
      end
      else if (CE_IN)
      begin
         sclk_s_r <= {sclk_s_r[1:0], SCLK_IN};
         cs_s_r <= {cs_s_r[1:0], CS_N_IN};
         mosi_s_r <= {mosi_s_r[1:0], MOSI_IN};
         if (sclk_s_r[1] == sclk_s_r[2])
            sclk_st_r <= sclk_s_r[2];
         if (cs_s_r[1] == cs_s_r[2])
            cs_st_r <= cs_s_r[2];
         if (mosi_s_r[1] == mosi_s_r[2])
            mosi_st_r <= mosi_s_r[2];
         sclk_prev_r <= sclk_st_r;
      end
   end

   assign sclk_rise = sclk_st_r & ~sclk_prev_r & ~cs_st_r;
   assign sclk_fall = ~sclk_st_r & sclk_prev_r & ~cs_st_r;

   // spi slave: 16-bit command, then 16 or 32 data bits, crc on non-burst reads
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         spi_state_r <= EPOC_IDLE;
         bit_cnt_r <= 6'h00;
         addr_r <= 12'h000;
         cmd_sh_r <= 16'h0000;
         rx_sh_r <= 32'h00000000;
         tx_sh_r <= 32'h00000000;
         crc_r <= `EPOC_CRC_INIT;
         miso_r <= 1'b0;
         miso_oe_r <= 1'b0;
         wr_stb_r <= 1'b0;
         wr_addr_r <= 12'h000;
         wr_data_r <= 32'h00000000;
      end
      else if (CE_IN)
      begin
         wr_stb_r <= 1'b0;
         miso_oe_r <= ~cs_st_r;
         if (cs_st_r)
         begin
            spi_state_r <= EPOC_CMD;
            bit_cnt_r <= 6'h00;
            miso_r <= 1'b0;
         end
         else if (sclk_rise)
         begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
            case (spi_state_r)
               EPOC_CMD:
               begin
                  cmd_sh_r <= {cmd_sh_r[14:0], mosi_st_r};
                  if (bit_cnt_r == 6'h0F)
                  begin
                     addr_r <= cmd_sh_r[14:3];
                     bit_cnt_r <= 6'h00;
                     if (cmd_sh_r[`EPOC_CMD_READ_BIT - 1])
                     begin
                        spi_state_r <= EPOC_RD;
                        tx_sh_r <= read_word(cmd_sh_r[14:3]);
                        crc_r <= `EPOC_CRC_INIT;
                     end
                     else
                        spi_state_r <= EPOC_WR;
                  end
               end
               EPOC_WR:
               begin
                  rx_sh_r <= {rx_sh_r[30:0], mosi_st_r};
                  if (bit_cnt_r == reg_width(addr_r) - 6'h01)
                  begin
                     wr_stb_r <= 1'b1;
                     wr_addr_r <= addr_r;
                     wr_data_r <= {rx_sh_r[30:0], mosi_st_r};
                     spi_state_r <= EPOC_IDLE;
                  end
               end
               EPOC_RD:
               begin
                  if (bit_cnt_r == reg_width(addr_r) - 6'h01)
                  begin
                     bit_cnt_r <= 6'h00;
                     if (cfg1_r[`EPOC_CFG1_BURST])
                     begin
                        addr_r <= addr_r + 12'h001;
                        tx_sh_r <= read_word(addr_r + 12'h001);
                     end
                     else
                     begin
                        spi_state_r <= EPOC_CRC;
                        tx_sh_r <= {crc_r, 16'h0000};
                     end
                  end
               end
               EPOC_CRC:
               begin
                  if (bit_cnt_r == 6'h0F)
                     spi_state_r <= EPOC_IDLE;
               end
               default:
                  bit_cnt_r <= bit_cnt_r;
            endcase
         end
         else if (sclk_fall && (spi_state_r == EPOC_RD || spi_state_r == EPOC_CRC))
         begin
            miso_r <= tx_sh_r[31];
            tx_sh_r <= {tx_sh_r[30:0], 1'b0};
            if (spi_state_r == EPOC_RD)
               crc_r <= {crc_r[14:0], 1'b0} ^ ((crc_r[15] ^ tx_sh_r[31]) ? `EPOC_CRC_POLY : 16'h0000);
         end
      end
   end

   // configuration registers
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         pwc_r <= `EPOC_PWC_RESET;
         cfg1_r <= `EPOC_CFG1_RESET;
         mode_r <= `EPOC_MODE_RESET;
         acc_r <= `EPOC_ACC_RESET;
         acc_clr_r <= 1'b0;
         sw_rst_r <= 1'b0;
      end
      else if (CE_IN)
      begin
         acc_clr_r <= 1'b0;
         sw_rst_r <= 1'b0;
         if (sw_rst_r)
         begin
            pwc_r <= `EPOC_PWC_RESET;
            cfg1_r <= `EPOC_CFG1_RESET;
            mode_r <= `EPOC_MODE_RESET;
            acc_r <= `EPOC_ACC_RESET;
         end
         else if (wr_stb_r)
         begin
            case (wr_addr_r)
               `EPOC_ADDR_PULSE_WIDTH: pwc_r <= wr_data_r & `EPOC_PWC_WMASK;
               `EPOC_ADDR_CONFIG_ONE:
               begin
                  cfg1_r <= wr_data_r[15:0] & `EPOC_CFG1_WMASK;
                  acc_clr_r <= wr_data_r[`EPOC_CFG1_ACC_CLR];
                  sw_rst_r <= wr_data_r[`EPOC_CFG1_SOFT_RESET];
               end
               `EPOC_ADDR_PULSE_MODE: mode_r <= wr_data_r[15:0] & `EPOC_MODE_WMASK;
               `EPOC_ADDR_ACCUM_MODE: acc_r <= wr_data_r[15:0] & `EPOC_ACC_WMASK;
               default: pwc_r <= pwc_r;
            endcase
         end
      end
   end

   assign pulse_evt = {SECOND_PULSE_EVT_IN, FIRST_PULSE_EVT_IN};
   assign pulse_dis = {mode_r[`EPOC_MODE_SECOND_DIS], mode_r[`EPOC_MODE_FIRST_DIS]};
   assign pulse_long = {pwc_r[`EPOC_PWC_SECOND_LT], pwc_r[`EPOC_PWC_FIRST_LT]};

   // one active-low pulse generator per output
   for (genvar g = 0; g < 2; g++)
   begin : ch
      logic low_r;
      logic pend_r;
      logic start_r;
      logic [19:0] cnt_r;
      logic [19:0] width;

      assign width = pulse_long[g] ? ((pwc_r[18:0] == 19'h00000) ? 20'h00001 : {1'b0, pwc_r[18:0]}) : FIXED_W;
      assign pulse_low[g] = low_r;
      assign pulse_start[g] = start_r;

      always_ff @(posedge CLK_IN or posedge RST_IN)
      begin
         if (RST_IN)
         begin
            low_r <= 1'b0;
            pend_r <= 1'b0;
            start_r <= 1'b0;
            cnt_r <= 20'h00000;
         end
         else if (CE_IN)
         begin
            start_r <= 1'b0;
            if (sw_rst_r || acc_clr_r)
            begin
               low_r <= 1'b0;
               pend_r <= 1'b0;
               cnt_r <= 20'h00000;
            end
            else if (low_r)
            begin
               // a new pulse cuts the current one short
               if (pulse_evt[g])
               begin
                  low_r <= 1'b0;
                  pend_r <= 1'b1;
               end
               else if (cnt_r <= 20'h00001)
                  low_r <= 1'b0;
               else
                  cnt_r <= cnt_r - 20'h00001;
            end
            else if (pulse_dis[g])
               pend_r <= 1'b0;
            else if (pulse_evt[g] || pend_r)
            begin
               low_r <= 1'b1;
               pend_r <= 1'b0;
               start_r <= 1'b1;
               cnt_r <= width;
            end
         end
      end
   end

   // pins and status flags, aligned to the falling edge
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         first_pin_r <= 1'b1;
         second_pin_r <= 1'b1;
         first_stat_r <= 1'b0;
         second_stat_r <= 1'b0;
      end
      else if (CE_IN)
      begin
         first_pin_r <= pulse_dis[0] | ~pulse_low[0];
         if (cfg1_r[`EPOC_CFG1_ZERO_CROSS_ROUTE])
            second_pin_r <= ZERO_CROSS_IN;
         else if (cfg1_r[`EPOC_CFG1_DRDY_ROUTE])
            second_pin_r <= SAMPLE_READY_IN;
         else
            second_pin_r <= pulse_dis[1] | ~pulse_low[1];
         first_stat_r <= pulse_start[0];
         second_stat_r <= pulse_start[1];
      end
   end

   // dip/swell interrupt style
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         dip_irq_r <= 1'b0;
         dip_prev_r <= 1'b0;
      end
      else if (CE_IN)
      begin
         dip_prev_r <= DIP_SWELL_ACTIVE_IN;
         if (cfg1_r[`EPOC_CFG1_DIP_MODE])
            dip_irq_r <= DIP_SWELL_ACTIVE_IN ^ dip_prev_r;
         else
            dip_irq_r <= DIP_SWELL_ACTIVE_IN & DIP_SWELL_CYCLE_IN;
      end
   end

   assign MISO_OUT = miso_r;
   assign MISO_OE_OUT = miso_oe_r;
   assign FIRST_PULSE_PIN_OUT = first_pin_r;
   assign SECOND_PULSE_PIN_OUT = second_pin_r;
   assign FIRST_PULSE_STATUS_OUT = first_stat_r;
   assign SECOND_PULSE_STATUS_OUT = second_stat_r;
   assign DIP_SWELL_IRQ_OUT = dip_irq_r;
   assign SECOND_ENERGY_TYPE_OUT = mode_r[5:3];
   assign FIRST_ENERGY_TYPE_OUT = mode_r[2:0];
   assign REACTIVE_ACCUM_MODE_OUT = acc_r[3:2];
   assign ACTIVE_ACCUM_MODE_OUT = acc_r[1:0];
   assign LINE_FREQ_60HZ_OUT = acc_r[`EPOC_ACC_FREQ];
   assign EXTERNAL_REF_SEL_OUT = cfg1_r[`EPOC_CFG1_EXTERNAL_REF];
   assign POWER_SETTLE_TIME_OUT = cfg1_r[`EPOC_CFG1_SETTLE_HI:`EPOC_CFG1_SETTLE_LO];
   assign ACCUM_CLEAR_OUT = acc_clr_r;
   assign SOFT_RESET_OUT = sw_rst_r;

endmodule // epoc_top

// File: inc/epoc_map.svh
// register offsets, field positions, reset values and timing for the pulse output config bank
`ifndef EPOC_MAP_SVH
`define EPOC_MAP_SVH

`define EPOC_ADDR_PULSE_WIDTH 12'h425
`define EPOC_ADDR_TRIM 12'h471
`define EPOC_ADDR_CONFIG_ONE 12'h481
`define EPOC_ADDR_PULSE_MODE 12'h490
`define EPOC_ADDR_ACCUM_MODE 12'h492

`define EPOC_PWC_SECOND_LT 20
`define EPOC_PWC_FIRST_LT 19
`define EPOC_PWC_WMASK 32'h001FFFFF
`define EPOC_PWC_RESET 32'h00000000

`define EPOC_CFG1_EXTERNAL_REF 15
`define EPOC_CFG1_DIP_MODE 14
`define EPOC_CFG1_BURST 11
`define EPOC_CFG1_SETTLE_HI 9
`define EPOC_CFG1_SETTLE_LO 8
`define EPOC_CFG1_ACC_CLR 5
`define EPOC_CFG1_ZERO_CROSS_ROUTE 2
`define EPOC_CFG1_DRDY_ROUTE 1
`define EPOC_CFG1_SOFT_RESET 0
`define EPOC_CFG1_WMASK 16'hCB06
`define EPOC_CFG1_RESET 16'h0300

`define EPOC_MODE_SECOND_DIS 7
`define EPOC_MODE_FIRST_DIS 6
`define EPOC_MODE_WMASK 16'h00FF
`define EPOC_MODE_RESET 16'h0000

`define EPOC_ACC_FREQ 4
`define EPOC_ACC_WMASK 16'h001F
`define EPOC_ACC_RESET 16'h0000

`define EPOC_CMD_READ_BIT 3
`define EPOC_CRC_POLY 16'h1021
`define EPOC_CRC_INIT 16'hFFFF

`define EPOC_FIXED_PULSE_MS 80
`define EPOC_CLK_HZ 10000000

`endif

// File: inc/epoc_pkg.sv
// types shared by the pulse output config bank
package epoc_pkg;
   typedef enum logic [4:0] {
      EPOC_IDLE = 5'b00001,
      EPOC_CMD = 5'b00010,
      EPOC_WR = 5'b00100,
      EPOC_RD = 5'b01000,
      EPOC_CRC = 5'b10000
   } epoc_spi_e;
   typedef logic [11:0] epoc_addr_t;
   typedef logic [1:0] epoc_accum_t;
   typedef logic [2:0] epoc_etype_t;
endpackage

// File: verif/epoc_props.sv
// assertion checker for the pulse output config bank
`timescale 1ns/100ps
module epoc_props (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // watched ports
   input wire logic CS_N_IN,
   input wire logic MISO_OE_OUT,
   input wire logic DIP_SWELL_ACTIVE_IN,
   input wire logic DIP_SWELL_CYCLE_IN,
   input wire logic DIP_SWELL_IRQ_OUT,
   input wire logic FIRST_PULSE_PIN_OUT,
   input wire logic SECOND_PULSE_PIN_OUT,
   input wire logic FIRST_PULSE_STATUS_OUT,
   input wire logic SECOND_PULSE_STATUS_OUT,
   input wire logic ACCUM_CLEAR_OUT,
   input wire logic SOFT_RESET_OUT,
   input wire epoc_pkg::epoc_etype_t FIRST_ENERGY_TYPE_OUT,
   input wire epoc_pkg::epoc_accum_t ACTIVE_ACCUM_MODE_OUT,
   input wire logic [1:0] POWER_SETTLE_TIME_OUT
);
   import epoc_pkg::*;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   sequence s_first_fall;
      $past(FIRST_PULSE_PIN_OUT) && !FIRST_PULSE_PIN_OUT;
   endsequence
   sequence s_second_fall;
      $past(SECOND_PULSE_PIN_OUT) && !SECOND_PULSE_PIN_OUT;
   endsequence
   property p_first_status;
      FIRST_PULSE_STATUS_OUT |-> s_first_fall;
   endproperty
   a_first_status: assert property (p_first_status) else $error("first status without pin fall");
   property p_first_fall;
      s_first_fall |-> FIRST_PULSE_STATUS_OUT;
   endproperty
   a_first_fall: assert property (p_first_fall) else $error("first pin fell without status");
   property p_second_status;
      SECOND_PULSE_STATUS_OUT |-> s_second_fall;
   endproperty
   a_second_status: assert property (p_second_status) else $error("second status without pin fall");
   property p_soft_once;
      SOFT_RESET_OUT |=> !SOFT_RESET_OUT;
   endproperty
   a_soft_once: assert property (p_soft_once) else $error("soft reset strobe too long");
   property p_soft_vals;
      SOFT_RESET_OUT |=> FIRST_PULSE_PIN_OUT && FIRST_ENERGY_TYPE_OUT == 3'h0 && ACTIVE_ACCUM_MODE_OUT == 2'h0
         && POWER_SETTLE_TIME_OUT == 2'h3;
   endproperty
   a_soft_vals: assert property (p_soft_vals) else $error("soft reset left config");
   property p_clear_once;
      ACCUM_CLEAR_OUT |=> !ACCUM_CLEAR_OUT;
   endproperty
   a_clear_once: assert property (p_clear_once) else $error("accum clear strobe too long");
   property p_irq;
      DIP_SWELL_IRQ_OUT |-> $past(DIP_SWELL_ACTIVE_IN && DIP_SWELL_CYCLE_IN)
         || $past(DIP_SWELL_ACTIVE_IN) != $past(DIP_SWELL_ACTIVE_IN, 2);
   endproperty
   a_irq: assert property (p_irq) else $error("dip irq without cause");
   property p_oe;
      CS_N_IN [*6] |-> !MISO_OE_OUT;
   endproperty
   a_oe: assert property (p_oe) else $error("miso driven while deselected");
endmodule // epoc_props
bind epoc_top epoc_props i_props (.CLK_IN, .RST_IN, .CS_N_IN, .MISO_OE_OUT, .DIP_SWELL_ACTIVE_IN,
   .DIP_SWELL_CYCLE_IN, .DIP_SWELL_IRQ_OUT, .FIRST_PULSE_PIN_OUT, .SECOND_PULSE_PIN_OUT, .FIRST_PULSE_STATUS_OUT,
   .SECOND_PULSE_STATUS_OUT, .ACCUM_CLEAR_OUT, .SOFT_RESET_OUT, .FIRST_ENERGY_TYPE_OUT, .ACTIVE_ACCUM_MODE_OUT,
   .POWER_SETTLE_TIME_OUT);

// File: verif/epoc_host.sv
// host side spi master model for the register bank
`timescale 1ns/100ps
module epoc_host (
   // clock
   input wire logic clk_in,
   // spi pins
   output logic sclk_out,
   output logic cs_n_out,
   output logic mosi_out,
   input wire logic miso_in
);
   initial
   begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   // mode 3 frame, 8 clk each half bit
   task automatic xfer(input logic [11:0] a, input logic rd, input int n, output logic [47:0] rq,
      input logic [31:0] wd);
      logic [63:0] sh;
      sh = {a, rd, 3'h0, wd << (32 - n), 16'h0};
      rq = '0;
      #5 cs_n_out = 1'b0;
      repeat (8) @(posedge clk_in);
      for (int k = 0; k < n + 16; k++)
      begin
         #5 sclk_out = 1'b0;
         mosi_out = sh[63 - k];
         repeat (8) @(posedge clk_in);
         #5 rq = {rq[46:0], miso_in};
         sclk_out = 1'b1;
         repeat (8) @(posedge clk_in);
      end
      #5 cs_n_out = 1'b1;
      // released line shows no stale value
      mosi_out = ~mosi_out;
      repeat (8) @(posedge clk_in);
   endtask
endmodule // epoc_host

// File: verif/tb.sv
// self-checking bench for the pulse output config bank
`timescale 1ns/100ps
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin err_total++; $display("wrong value at %0t: %h not %h", $time, g, x); end end
module tb;
   import epoc_pkg::*;
   localparam int FIX = 20;
   logic CLK_IN, RST_IN, CE_IN, SCLK_IN, CS_N_IN, MOSI_IN, FIRST_PULSE_EVT_IN, SECOND_PULSE_EVT_IN, go;
   logic ZERO_CROSS_IN, SAMPLE_READY_IN, DIP_SWELL_ACTIVE_IN, DIP_SWELL_CYCLE_IN, MISO_OUT, MISO_OE_OUT;
   logic [15:0] TRIM_OFFSET_IN, TRIM_GAIN_IN;
   logic FIRST_PULSE_PIN_OUT, SECOND_PULSE_PIN_OUT, FIRST_PULSE_STATUS_OUT, SECOND_PULSE_STATUS_OUT;
   logic DIP_SWELL_IRQ_OUT, LINE_FREQ_60HZ_OUT, EXTERNAL_REF_SEL_OUT, ACCUM_CLEAR_OUT, SOFT_RESET_OUT;
   epoc_etype_t FIRST_ENERGY_TYPE_OUT, SECOND_ENERGY_TYPE_OUT;
   epoc_accum_t ACTIVE_ACCUM_MODE_OUT, REACTIVE_ACCUM_MODE_OUT;
   logic [1:0] POWER_SETTLE_TIME_OUT;
   int err_total, num_checks, cyc, seed, clr_n, srst_n;
   logic [31:0] mdl [int];
   int tbl [6] = '{12'h425, 12'h471, 12'h481, 12'h490, 12'h492, 12'h4A0};
   wire logic [1:0] pin = {SECOND_PULSE_PIN_OUT, FIRST_PULSE_PIN_OUT};
   wire logic [1:0] sts = {SECOND_PULSE_STATUS_OUT, FIRST_PULSE_STATUS_OUT};
   epoc_host i_host (.clk_in(CLK_IN), .sclk_out(SCLK_IN), .cs_n_out(CS_N_IN), .mosi_out(MOSI_IN), .miso_in(MISO_OUT));
   epoc_top #(.FIXED_PULSE_CYC(FIX)) i_dut (.CLK_IN, .RST_IN, .CE_IN, .SCLK_IN, .CS_N_IN, .MOSI_IN, .MISO_OUT,
      .MISO_OE_OUT, .FIRST_PULSE_EVT_IN, .SECOND_PULSE_EVT_IN, .ZERO_CROSS_IN, .SAMPLE_READY_IN,
      .DIP_SWELL_ACTIVE_IN, .DIP_SWELL_CYCLE_IN, .TRIM_OFFSET_IN, .TRIM_GAIN_IN, .FIRST_PULSE_PIN_OUT,
      .SECOND_PULSE_PIN_OUT, .FIRST_PULSE_STATUS_OUT, .SECOND_PULSE_STATUS_OUT, .DIP_SWELL_IRQ_OUT,
      .FIRST_ENERGY_TYPE_OUT, .SECOND_ENERGY_TYPE_OUT, .ACTIVE_ACCUM_MODE_OUT, .REACTIVE_ACCUM_MODE_OUT,
      .LINE_FREQ_60HZ_OUT, .EXTERNAL_REF_SEL_OUT, .POWER_SETTLE_TIME_OUT, .ACCUM_CLEAR_OUT, .SOFT_RESET_OUT);
   initial
   begin
      CLK_IN = 1'b0;
      forever #50 CLK_IN = ~CLK_IN;
   end
   function automatic int wid(int a);
      return (a == 12'h425 || a == 12'h471) ? 32 : 16;
   endfunction
   function automatic logic [31:0] wm(int a);
      case (a)
         12'h425: return 32'h1FFFFF;
         12'h481: return 32'hCB06;
         12'h490: return 32'hFF;
         default: return 32'h1F;
      endcase
   endfunction
   function automatic logic [31:0] ev(int a);
      if (a == 12'h471)
         return {TRIM_OFFSET_IN, TRIM_GAIN_IN};
      return mdl.exists(a) ? mdl[a] : 32'h0;
   endfunction
   function automatic logic [15:0] crc(logic [31:0] d, int n);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = n - 1; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
      return c;
   endfunction
   task automatic mreset;
      mdl[12'h425] = 32'h0;
      mdl[12'h481] = 32'h300;
      mdl[12'h490] = 32'h0;
      mdl[12'h492] = 32'h0;
   endtask
   task automatic wr(int a, logic [31:0] wd);
      logic [47:0] q;
      i_host.xfer(a[11:0], 1'b0, wid(a), q, wd);
      if (mdl.exists(a))
         mdl[a] = wd & wm(a);
      if (a == 12'h481 && wd[0])
         mreset();
   endtask
   task automatic rd(int a, int n);
      logic [47:0] q, e;
      logic b;
      int k;
      b = mdl[12'h481][11];
      k = 0;
      e = '0;
      if (n == 0)
         n = b ? wid(a) : wid(a) + 16;
      i_host.xfer(a[11:0], 1'b1, n, q, 32'h0);
      if (!b)
         e = {ev(a), crc(ev(a), wid(a))};
      else
         while (k < n)
         begin
            e = (e << wid(a)) | ev(a);
            k += wid(a);
            a++;
         end
      `CHK(q & ((48'h1 << n) - 48'h1), e)
   endtask
   task automatic cfg_chk;
      `CHK(FIRST_ENERGY_TYPE_OUT, mdl[12'h490][2:0])
      `CHK(SECOND_ENERGY_TYPE_OUT, mdl[12'h490][5:3])
      `CHK(ACTIVE_ACCUM_MODE_OUT, mdl[12'h492][1:0])
      `CHK(REACTIVE_ACCUM_MODE_OUT, mdl[12'h492][3:2])
      `CHK(LINE_FREQ_60HZ_OUT, mdl[12'h492][4])
      `CHK(EXTERNAL_REF_SEL_OUT, mdl[12'h481][15])
      `CHK(POWER_SETTLE_TIME_OUT, mdl[12'h481][9:8])
   endtask
   task automatic pulse(int s, logic lt, int t, logic ds);
      int lo, st;
      lo = 0;
      st = 0;
      wr(12'h490, ds ? 32'h40 << s : 32'h0);
      wr(12'h425, (lt ? 32'h80000 << s : 32'h0) | t);
      #5 {SECOND_PULSE_EVT_IN, FIRST_PULSE_EVT_IN} = 2'h1 << s;
      @(posedge CLK_IN);
      #5 {SECOND_PULSE_EVT_IN, FIRST_PULSE_EVT_IN} = 2'h0;
      repeat (40)
      begin
         @(posedge CLK_IN);
         #5 lo += (pin[s] === 1'b0) ? 1 : 0;
         st += (sts[s] === 1'b1) ? 1 : 0;
      end
      @(posedge CLK_IN);
      `CHK(lo, ds ? 0 : lt ? (t == 0 ? 1 : t) : FIX)
      `CHK(st, ds ? 0 : 1)
   endtask
   task automatic route(logic [31:0] wd);
      logic v;
      wr(12'h481, wd);
      for (int k = 0; k < 9; k++)
      begin
         #5 if (k > 0) `CHK(SECOND_PULSE_PIN_OUT, v)
         ZERO_CROSS_IN = 1'($random(seed));
         SAMPLE_READY_IN = 1'($random(seed));
         v = wd[2] ? ZERO_CROSS_IN : SAMPLE_READY_IN;
         @(posedge CLK_IN);
      end
   endtask
   task automatic end_sim;
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge CLK_IN)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         err_total++;
         end_sim();
      end
   end
   // random dip condition only while go, strobe counts
   always @(posedge CLK_IN)
   begin
      #5 DIP_SWELL_ACTIVE_IN = go && (DIP_SWELL_ACTIVE_IN ^ ($random(seed) % 8 == 0));
      DIP_SWELL_CYCLE_IN = go && ($random(seed) % 3 == 0);
      clr_n += ACCUM_CLEAR_OUT;
      srst_n += SOFT_RESET_OUT;
   end
   initial
   begin
      seed = 73151;
      err_total = 0;
      num_checks = 0;
      cyc = 0;
      clr_n = 0;
      srst_n = 0;
      go = 1'b0;
      CE_IN = 1'b1;
      RST_IN = 1'b1;
      {SECOND_PULSE_EVT_IN, FIRST_PULSE_EVT_IN} = 2'h0;
      ZERO_CROSS_IN = 1'b0;
      SAMPLE_READY_IN = 1'b0;
      TRIM_OFFSET_IN = 16'($random(seed));
      TRIM_GAIN_IN = 16'($random(seed));
      mreset();
      repeat (2) @(posedge CLK_IN);
      #5 RST_IN = 1'b0;
      repeat (6) @(posedge CLK_IN);
      cfg_chk();
      for (int i = 0; i < 6; i++)
         rd(tbl[i], 0);
      go = 1'b1;
      for (int i = 0; i < 18; i++)
      begin
         wr(tbl[i % 6], $random(seed) & 32'hFFFFFFDE);
         rd(tbl[i % 6], 0);
         cfg_chk();
      end
      go = 1'b0;
      wr(12'h481, 32'h800);
      rd(12'h490, 48);
      rd(12'h425, 0);
      wr(12'h481, 32'h8020);
      `CHK(clr_n, 1)
      rd(12'h481, 0);
      cfg_chk();
      wr(12'h481, 32'h1);
      `CHK(srst_n, 1)
      for (int i = 0; i < 6; i++)
         rd(tbl[i], 0);
      cfg_chk();
      pulse(0, 1'b1, 7, 1'b0);
      pulse(1, 1'b1, 5, 1'b0);
      pulse(0, 1'b0, 9, 1'b0);
      pulse(1, 1'b0, 9, 1'b0);
      pulse(0, 1'b1, 0, 1'b0);
      pulse(0, 1'b0, 0, 1'b1);
      pulse(1, 1'b0, 0, 1'b1);
      route(32'h4);
      route(32'h2);
      route(32'h6);
      end_sim();
   end
endmodule // tb
